// >>> hdl/lpcs_regs.svh
// Register offsets, field positions, reset values and timing codes of the calibration scheduler
`ifndef LPCS_REGS_SVH
`define LPCS_REGS_SVH

// ==========================================
// Offsets
`define LPCS_OFF_CONTROL 8'h6E
`define LPCS_OFF_SOFT_TRIG 8'h6C
`define LPCS_OFF_GAIN_TRIM 8'h7A
`define LPCS_OFF_REFERENCE_VOLTAGE_ADJUST 8'h7C

// ==========================================
// Register fields
`define LPCS_SLEEP_MSB 7
`define LPCS_SLEEP_LSB 5
`define LPCS_WAKE_MSB 4
`define LPCS_WAKE_LSB 3
`define LPCS_RSVD_BIT 2
`define LPCS_TRIGMODE_BIT 1
`define LPCS_ENABLE_BIT 0
`define LPCS_SOFT_TRIG_BIT 0
`define LPCS_SRC_SEL_BIT 1
`define LPCS_BGSEL_BIT 2
`define LPCS_REFERENCE_VOLTAGE_ADJUST_MSB 3

// ==========================================
// Reset values
`define LPCS_RST_CONTROL 8'h88
`define LPCS_RST_SOFT_TRIG 8'h01

// ==========================================
// Interval table, in sample clock periods
`define LPCS_DLY_C0 41'h000_0000_0480
`define LPCS_DLY_C1 41'h000_0040_0080
`define LPCS_DLY_C2 41'h000_0200_0080
`define LPCS_DLY_C3 41'h000_1000_0080
`define LPCS_DLY_C4 41'h000_8000_0080
`define LPCS_DLY_C5 41'h004_0000_0080
`define LPCS_DLY_C6 41'h020_0000_0080
`define LPCS_DLY_C7 41'h100_0000_0080

`endif

// >>> hdl/lpcs_pkg.sv
// Types shared by the calibration scheduler
package lpcs_pkg;
  typedef enum logic [1:0] {LPCS_ST_IDLE, LPCS_ST_SLEEP, LPCS_ST_SETTLE, LPCS_ST_CAL} lpcs_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lpcs_bus_req_t;
  typedef struct packed {
    logic core_sleep;
    logic core_settle;
    logic cal_start;
  } lpcs_core_ctl_t;
endpackage : lpcs_pkg

// >>> hdl/lpcs_pin_sync.sv
// Three-stage input synchroniser with agreement detection
`timescale 1ns/1ps
module lpcs_pin_sync (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic pin_in,
  output logic level_q
);
  logic [2:0] sync_q;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], pin_in};
    end
  end

  // Second and third stage must agree before the level moves
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      level_q <= 1'b0;
    end else if (sync_q[1] == sync_q[2]) begin
      level_q <= sync_q[2];
    end
  end
endmodule : lpcs_pin_sync

// >>> hdl/lpcs_scheduler.sv
// Low-power background calibration scheduler with trim registers
`timescale 1ns/1ps
`include "lpcs_regs.svh"

module lpcs_scheduler #(
  parameter logic [40:0] SLEEP_C4 = `LPCS_DLY_C4,
  parameter logic [40:0] WAKE_C1 = `LPCS_DLY_C2
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire lpcs_pkg::lpcs_bus_req_t bus_req,
  output logic [7:0] rdata_q,
  input wire logic [7:0] fuse_gain_trim,
  input wire logic [3:0] fuse_reference_voltage_adjust,
  input wire logic external_cal_trigger_input,
  input wire logic cal_done,
  output lpcs_pkg::lpcs_core_ctl_t core_ctl_q,
  output logic [7:0] gain_trim_q,
  output logic [3:0] reference_voltage_adjust_q
);
  // ==========================================
  // Registers
  logic [7:0] control_q;
  logic [1:0] soft_q;
  logic bgsel_q;
  logic fuse_load_q;
  logic ext_trig;
  lpcs_pkg::lpcs_state_t state_q;
  logic [40:0] count_q;
  logic [40:0] limit;
  logic [2:0] sleep_interval_code;
  logic [1:0] wake_settle_code;
  logic trigger_driven_sleep;
  logic lowpower_cal_enable;
  logic background_cal_select;
  logic trigger_source_select;
  logic software_cal_trigger;
  logic cal_trigger;
  logic active;

  assign sleep_interval_code = control_q[`LPCS_SLEEP_MSB:`LPCS_SLEEP_LSB];
  assign wake_settle_code = control_q[`LPCS_WAKE_MSB:`LPCS_WAKE_LSB];
  assign trigger_driven_sleep = control_q[`LPCS_TRIGMODE_BIT];
  assign lowpower_cal_enable = control_q[`LPCS_ENABLE_BIT];
  assign software_cal_trigger = soft_q[`LPCS_SOFT_TRIG_BIT];
  assign trigger_source_select = soft_q[`LPCS_SRC_SEL_BIT];
  assign background_cal_select = bgsel_q;

  lpcs_pin_sync u_trig_sync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .pin_in(external_cal_trigger_input),
    .level_q(ext_trig)
  );

  // Unselected source is ignored
  assign cal_trigger = trigger_source_select ? ext_trig : software_cal_trigger;
  assign active = lowpower_cal_enable && background_cal_select;

  // ==========================================
  // Register writes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      control_q <= `LPCS_RST_CONTROL;
    end else if (bus_req.wr && bus_req.addr == `LPCS_OFF_CONTROL) begin
      // Bit 2 is stored as written; keeping it zero is up to software
      control_q <= bus_req.wdata;
    end
  end

  // Trigger source register resets to a high software trigger, the safe idle level
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      soft_q <= 2'(`LPCS_RST_SOFT_TRIG);
      bgsel_q <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == `LPCS_OFF_SOFT_TRIG) begin
      soft_q <= bus_req.wdata[`LPCS_SRC_SEL_BIT:`LPCS_SOFT_TRIG_BIT];
      bgsel_q <= bus_req.wdata[`LPCS_BGSEL_BIT];
    end
  end

  // Fuse values are captured on the first clock after reset release
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      fuse_load_q <= 1'b1;
    end else begin
      fuse_load_q <= 1'b0;
    end
  end

  // A bus write in the load cycle loses to the fuses
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      gain_trim_q <= 8'h00;
      reference_voltage_adjust_q <= 4'h0;
    end else if (fuse_load_q) begin
      gain_trim_q <= fuse_gain_trim;
      reference_voltage_adjust_q <= fuse_reference_voltage_adjust;
    end else if (bus_req.wr) begin
      if (bus_req.addr == `LPCS_OFF_GAIN_TRIM) begin
        gain_trim_q <= bus_req.wdata;
      end
      if (bus_req.addr == `LPCS_OFF_REFERENCE_VOLTAGE_ADJUST) begin
        reference_voltage_adjust_q <= bus_req.wdata[`LPCS_REFERENCE_VOLTAGE_ADJUST_MSB:0];
      end
    end
  end

  // ==========================================
  // Read port; unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `LPCS_OFF_CONTROL: rdata_q <= control_q;
        `LPCS_OFF_SOFT_TRIG: rdata_q <= {5'h00, bgsel_q, soft_q};
        `LPCS_OFF_GAIN_TRIM: rdata_q <= gain_trim_q;
        `LPCS_OFF_REFERENCE_VOLTAGE_ADJUST: rdata_q <= {4'h0, reference_voltage_adjust_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // ==========================================
  // Interval lookup
  always_comb begin
    limit = `LPCS_DLY_C0;
    if (state_q == lpcs_pkg::LPCS_ST_SETTLE) begin
      unique case (wake_settle_code)
        2'h0: limit = `LPCS_DLY_C0;
        2'h1: limit = WAKE_C1;
        2'h2: limit = `LPCS_DLY_C3;
        2'h3: limit = `LPCS_DLY_C4;
      endcase
    end else begin
      unique case (sleep_interval_code)
        3'h0: limit = `LPCS_DLY_C0;
        3'h1: limit = `LPCS_DLY_C1;
        3'h2: limit = `LPCS_DLY_C2;
        3'h3: limit = `LPCS_DLY_C3;
        3'h4: limit = SLEEP_C4;
        3'h5: limit = `LPCS_DLY_C5;
        3'h6: limit = `LPCS_DLY_C6;
        3'h7: limit = `LPCS_DLY_C7;
      endcase
    end
  end

  // ==========================================
  // Sleep / settle / calibrate sequence
  logic sleep_done;
  logic settle_done;
  assign sleep_done = trigger_driven_sleep ? !cal_trigger
                                           : (count_q >= limit - 41'h1);
  assign settle_done = count_q >= limit - 41'h1;

  always_ff @(posedge ref_clk) begin
    if (!reset_n || !active) begin
      state_q <= lpcs_pkg::LPCS_ST_IDLE;
      count_q <= 41'h0;
    end else begin
      count_q <= count_q + 41'h1;
      unique case (state_q)
        lpcs_pkg::LPCS_ST_IDLE: begin
          state_q <= lpcs_pkg::LPCS_ST_SLEEP;
          count_q <= 41'h0;
        end
        lpcs_pkg::LPCS_ST_SLEEP: begin
          if (sleep_done) begin
            state_q <= lpcs_pkg::LPCS_ST_SETTLE;
            count_q <= 41'h0;
          end
        end
        lpcs_pkg::LPCS_ST_SETTLE: begin
          if (settle_done) begin
            state_q <= lpcs_pkg::LPCS_ST_CAL;
            count_q <= 41'h0;
          end
        end
        lpcs_pkg::LPCS_ST_CAL: begin
          if (cal_done) begin
            state_q <= lpcs_pkg::LPCS_ST_SLEEP;
            count_q <= 41'h0;
          end
        end
      endcase
    end
  end

  // Core sleep and settle are registered copies of the phase; cal_start flags the last settle cycle
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      core_ctl_q <= '0;
    end else begin
      core_ctl_q.core_sleep <= active && state_q == lpcs_pkg::LPCS_ST_SLEEP;
      core_ctl_q.core_settle <= active && state_q == lpcs_pkg::LPCS_ST_SETTLE;
      core_ctl_q.cal_start <= active && state_q == lpcs_pkg::LPCS_ST_SETTLE && settle_done;
    end
  end

  // ==========================================
  // Assertions
  AST_DISABLED_IDLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !active |=> state_q == lpcs_pkg::LPCS_ST_IDLE)
    else $error("scheduler runs while disabled");
  AST_TRIG_HOLDS_SLEEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (active && trigger_driven_sleep && cal_trigger && state_q == lpcs_pkg::LPCS_ST_SLEEP)
      |=> state_q == lpcs_pkg::LPCS_ST_SLEEP)
    else $error("core woke with trigger high");
  AST_TRIG_WAKES: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (active && trigger_driven_sleep && !cal_trigger && state_q == lpcs_pkg::LPCS_ST_SLEEP)
      |=> state_q != lpcs_pkg::LPCS_ST_SLEEP || !active)
    else $error("low trigger did not wake core");
  AST_COUNT_RESTART: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q != $past(state_q)) |-> count_q == 41'h0)
    else $error("counter did not restart on phase change");
  AST_SETTLE_MIN: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == lpcs_pkg::LPCS_ST_CAL && $past(state_q) == lpcs_pkg::LPCS_ST_SETTLE)
      |-> $past(count_q) == $past(limit) - 41'h1 || $past(wake_settle_code) != wake_settle_code)
    else $error("settle interval wrong length");
  AST_AUTO_SLEEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (active && !trigger_driven_sleep && state_q == lpcs_pkg::LPCS_ST_SLEEP
      && count_q < limit - 41'h1) |=> state_q != lpcs_pkg::LPCS_ST_SETTLE)
    else $error("autonomous sleep ended early");
  AST_SRC_SELECT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !trigger_source_select |-> cal_trigger == software_cal_trigger)
    else $error("external trigger used while software selected");
  AST_BG_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $past(bus_req.rd && bus_req.addr == `LPCS_OFF_REFERENCE_VOLTAGE_ADJUST) |-> rdata_q[7:4] == 4'h0)
    else $error("band-gap reserved bits not zero");
  AST_FUSE_LOAD: assert property (@(posedge ref_clk) disable iff (!reset_n)
    fuse_load_q |=> reference_voltage_adjust_q == $past(fuse_reference_voltage_adjust) && gain_trim_q == $past(fuse_gain_trim))
    else $error("fuse values not loaded");
  AST_CORE_SLEEP_PHASE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    core_ctl_q.core_sleep |-> $past(active && state_q == lpcs_pkg::LPCS_ST_SLEEP))
    else $error("core asleep outside sleep phase");
  AST_CAL_AFTER_SETTLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (state_q == lpcs_pkg::LPCS_ST_CAL && $past(state_q) != lpcs_pkg::LPCS_ST_CAL)
      |-> $past(state_q) == lpcs_pkg::LPCS_ST_SETTLE)
    else $error("calibration began without settling");
  AST_CAL_START_PULSE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    core_ctl_q.cal_start |=> !core_ctl_q.cal_start)
    else $error("calibration start longer than one cycle");
  AST_CAL_HOLDS: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (active && state_q == lpcs_pkg::LPCS_ST_CAL && !cal_done)
      |=> state_q == lpcs_pkg::LPCS_ST_CAL)
    else $error("calibration phase left before done");
  AST_AUTO_WAKE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (active && !trigger_driven_sleep && state_q == lpcs_pkg::LPCS_ST_SLEEP
      && count_q == limit - 41'h1) |=> state_q == lpcs_pkg::LPCS_ST_SETTLE)
    else $error("autonomous sleep overran its interval");
  AST_EXT_SELECT: assert property (@(posedge ref_clk) disable iff (!reset_n)
    trigger_source_select |-> cal_trigger == ext_trig)
    else $error("software trigger used while external selected");
  // Trim checks skip the load cycle, in which the fuses win over the bus
  AST_GAIN_STABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!fuse_load_q && !(bus_req.wr && bus_req.addr == `LPCS_OFF_GAIN_TRIM))
      |=> $stable(gain_trim_q))
    else $error("gain trim changed without a write");
  AST_GAIN_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!fuse_load_q && bus_req.wr && bus_req.addr == `LPCS_OFF_GAIN_TRIM)
      |=> gain_trim_q == $past(bus_req.wdata))
    else $error("gain trim write lost");
  AST_BG_STABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!fuse_load_q && !(bus_req.wr && bus_req.addr == `LPCS_OFF_REFERENCE_VOLTAGE_ADJUST))
      |=> $stable(reference_voltage_adjust_q))
    else $error("band-gap trim changed without a write");
  AST_BG_WRITE: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!fuse_load_q && bus_req.wr && bus_req.addr == `LPCS_OFF_REFERENCE_VOLTAGE_ADJUST)
      |=> reference_voltage_adjust_q == $past(bus_req.wdata[`LPCS_REFERENCE_VOLTAGE_ADJUST_MSB:0]))
    else $error("band-gap trim write lost");

  // ==========================================
  // Coverage of the main scenarios
  COV_SLEEP_TO_SETTLE: cover property (@(posedge ref_clk)
    state_q == lpcs_pkg::LPCS_ST_SLEEP ##1 state_q == lpcs_pkg::LPCS_ST_SETTLE);
  COV_CAL_START: cover property (@(posedge ref_clk) core_ctl_q.cal_start);
  COV_TRIG_WAKE: cover property (@(posedge ref_clk)
    trigger_driven_sleep && state_q == lpcs_pkg::LPCS_ST_SLEEP ##1 state_q == lpcs_pkg::LPCS_ST_SETTLE);
  COV_DISABLE_MIDRUN: cover property (@(posedge ref_clk) active ##1 !active);
  COV_EXT_WAKE: cover property (@(posedge ref_clk)
    trigger_source_select && trigger_driven_sleep && !cal_trigger
      && state_q == lpcs_pkg::LPCS_ST_SLEEP);
endmodule : lpcs_scheduler

// >>> tb/tb.sv
// Self-checking bench for the calibration scheduler and trim registers
`timescale 1ns/1ps
`include "lpcs_regs.svh"
module tb;
  // ==========================================
  // Signals
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  lpcs_pkg::lpcs_bus_req_t bus = '0;
  logic [7:0] rdata_q;
  logic ext_trig = 1'b1;
  logic cal_done = 1'b0;
  lpcs_pkg::lpcs_core_ctl_t core_ctl_q;
  logic [7:0] gain_trim_q;
  logic [3:0] reference_voltage_adjust_q;
  logic [7:0] rd_val;
  logic [7:0] n;
  int num_errors = 0;
  int total_checks = 0;
  int cal_cnt = 0;
  int cal_prev = 0;

  always #2 ref_clk = ~ref_clk;

  // Start pulses are counted off-edge; one can end before a task looks
  always @(negedge ref_clk) begin
    if (core_ctl_q.cal_start === 1'b1) begin
      cal_cnt++;
    end
  end

  // Short interval parameters keep the run brief
  lpcs_scheduler #(.SLEEP_C4(41'h000_0000_0014), .WAKE_C1(41'h000_0000_000A)) dut_u (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .bus_req(bus),
    .rdata_q(rdata_q),
    .fuse_gain_trim(8'h5A),
    .fuse_reference_voltage_adjust(4'h9),
    .external_cal_trigger_input(ext_trig),
    .cal_done(cal_done),
    .core_ctl_q(core_ctl_q),
    .gain_trim_q(gain_trim_q),
    .reference_voltage_adjust_q(reference_voltage_adjust_q)
  );

  // ==========================================
  // Helpers
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) bus.wr <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) bus.rd <= 1'b0;
    #1 rd_val = rdata_q;
  endtask : rd

  function automatic logic sel(input int w);
    return (w == 0) ? core_ctl_q.core_sleep : (w == 1) ? core_ctl_q.core_settle
                                                       : core_ctl_q.cal_start;
  endfunction : sel

  task automatic wait_hi(input int w, input int bound);
    int i;
    i = 0;
    while (sel(w) !== 1'b1 && i < bound) begin
      @(posedge ref_clk) #1 i++;
    end
    chk("phase reached", {7'h00, sel(w)}, 8'h01);
  endtask : wait_hi

  task automatic run_len(input int w);
    n = 8'h00;
    while (sel(w) === 1'b1 && n < 8'hFF) begin
      @(posedge ref_clk) #1 n++;
    end
  endtask : run_len

  task automatic finish_cal();
    int i;
    i = 0;
    while (cal_cnt == cal_prev && i < 12) begin
      @(posedge ref_clk) #1 i++;
    end
    chk("cal start pulses", 8'(cal_cnt - cal_prev), 8'h01);
    cal_prev = cal_cnt;
    @(posedge ref_clk) cal_done <= 1'b1;
    @(posedge ref_clk) cal_done <= 1'b0;
  endtask : finish_cal

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(`LPCS_OFF_CONTROL); chk("control reset", rd_val, 8'h88);
    rd(`LPCS_OFF_SOFT_TRIG); chk("soft trig reset", rd_val, 8'h01);
    rd(`LPCS_OFF_GAIN_TRIM); chk("gain fuse", rd_val, 8'h5A);
    rd(`LPCS_OFF_REFERENCE_VOLTAGE_ADJUST); chk("bg fuse", rd_val, 8'h09);
    rd(8'h10); chk("unmapped read", rd_val, 8'h00);
    chk("core idle", {5'h00, core_ctl_q}, 8'h00);
    $display("test reset done");
  endtask : t_reset

  task automatic t_trims();
    wr(`LPCS_OFF_GAIN_TRIM, 8'hA5);
    wr(`LPCS_OFF_REFERENCE_VOLTAGE_ADJUST, 8'h06);
    rd(`LPCS_OFF_GAIN_TRIM); chk("gain rw", rd_val, 8'hA5);
    chk("gain out", gain_trim_q, 8'hA5);
    rd(`LPCS_OFF_REFERENCE_VOLTAGE_ADJUST); chk("bg rw", rd_val, 8'h06);
    chk("bg out", {4'h0, reference_voltage_adjust_q}, 8'h06);
    $display("test trims done");
  endtask : t_trims

  task automatic t_auto();
    wr(`LPCS_OFF_SOFT_TRIG, 8'h05);
    wr(`LPCS_OFF_CONTROL, 8'h89);
    wait_hi(0, 4);
    wait_hi(1, 40);
    run_len(1); chk("settle length", n, 8'h0A);
    finish_cal();
    wait_hi(0, 4);
    run_len(0); chk("sleep length", n, 8'h14);
    wait_hi(1, 2);
    run_len(1); chk("settle again", n, 8'h0A);
    finish_cal();
    wr(`LPCS_OFF_CONTROL, 8'h88);
    repeat (2) @(posedge ref_clk);
    #1 chk("disabled", {5'h00, core_ctl_q}, 8'h00);
    $display("test autonomous done");
  endtask : t_auto

  task automatic t_trig();
    wr(`LPCS_OFF_CONTROL, 8'h8B);
    wait_hi(0, 4);
    repeat (40) @(posedge ref_clk);
    #1 chk("held asleep", {7'h00, core_ctl_q.core_sleep}, 8'h01);
    wr(`LPCS_OFF_SOFT_TRIG, 8'h04);
    wait_hi(1, 4);
    run_len(1); chk("trig settle", n, 8'h0A);
    wr(`LPCS_OFF_SOFT_TRIG, 8'h06);
    finish_cal();
    wait_hi(0, 4);
    repeat (40) @(posedge ref_clk);
    #1 chk("soft ignored", {7'h00, core_ctl_q.core_sleep}, 8'h01);
    @(posedge ref_clk) ext_trig <= 1'b0;
    wait_hi(1, 10);
    finish_cal();
    wr(`LPCS_OFF_CONTROL, 8'h88);
    @(posedge ref_clk) ext_trig <= 1'b1;
    $display("test trigger done");
  endtask : t_trig

  task automatic t_gate();
    wr(`LPCS_OFF_SOFT_TRIG, 8'h01);
    wr(`LPCS_OFF_CONTROL, 8'h89);
    n = 8'h00;
    repeat (40) begin
      @(posedge ref_clk) #1 if (core_ctl_q !== 3'b000) n++;
    end
    chk("needs background", n, 8'h00);
    $display("test gating done");
  endtask : t_gate

  // ==========================================
  // Sequence and verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_trims();
    t_auto();
    t_trig();
    t_gate();
    test_done();
  end

  // Whole run needs well under two thousand cycles
  initial begin
    #40000;
    num_errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    test_done();
  end
endmodule : tb
